// ===== shared/mbag_defines.vh
// Purpose: constants for the modulo / bit-reversed address generator
// Assumes: 16-bit data addresses, 32-bit apb data
// Notes:   included by rtl/mbag_top.v and rtl/mbag_modwrap.v
`ifndef MBAG_DEFINES_VH
`define MBAG_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define MBAG_OFF_BREV      8'h00
`define MBAG_OFF_MODCTL    8'h04
`define MBAG_OFF_MODSTART  8'h08
`define MBAG_OFF_MODEND    8'h0C
`define MBAG_OFF_STATUS    8'h10

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define MBAG_BREV_EN_BIT   15
`define MBAG_BREV_MOD_MSB  14
`define MBAG_MOD_EN_BIT    15
`define MBAG_BWP_MSB       7
`define MBAG_BWP_LSB       4
`define MBAG_XWP_MSB       3
`define MBAG_XWP_LSB       0
`define MBAG_RST16         16'h0000
`define MBAG_STACK_SEL     4'hF

// ------------------------------------------------------------
// addressing modes from the pipeline
// ------------------------------------------------------------
`define MBAG_AM_IND        3'h0
`define MBAG_AM_POSTINC    3'h1
`define MBAG_AM_POSTDEC    3'h2
`define MBAG_AM_PREINC     3'h3
`define MBAG_AM_PREDEC     3'h4
`define MBAG_AM_OFFSET     3'h5

// ------------------------------------------------------------
// access steps
// ------------------------------------------------------------
`define MBAG_STEP_BYTE     16'h0001
`define MBAG_STEP_WORD     16'h0002

`endif

// ===== rtl/mbag_modwrap.v
// Purpose: modulo boundary correction of one address
// Assumes: start <= end, buffer inside 16-bit space
// Notes:   purely combinational
`include "mbag_defines.vh"

module mbag_modwrap
#(
  parameter AW = 16
)
(
  // control
  input  wire          en_in,
  input  wire          dec_in,
  // bounds and value
  input  wire [AW-1:0] start_in,
  input  wire [AW-1:0] end_in,
  input  wire [AW-1:0] addr_in,
  // result
  output reg  [AW-1:0] addr_out
);

  wire [AW-1:0] len;

  assign len = end_in - start_in + {{(AW-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------
  // boundary check, beyond as well as equal
  // ----------------------------------------------------------
  always @*
  begin
    addr_out = addr_in;
    if (en_in && !dec_in && (addr_in > end_in))     // see RULE_02 see RULE_03
    begin
      addr_out = addr_in - len;
    end
    else if (en_in && dec_in && (addr_in < start_in)) // see RULE_02 see RULE_03
    begin
      addr_out = addr_in + len;
    end
  end

endmodule

// ===== rtl/mbag_top.v
// Purpose: effective address generator with modulo and bit-reversed modes
// Assumes: apb slave, pipeline requests on clk_in, one request per cycle
// Notes:   results appear one cycle after the request
//
// Behaviour
// RULE_01: modulo correction may apply to any selected working register.
// RULE_02: incrementing checks upper bound, decrementing checks lower bound.
// RULE_03: addresses beyond a bound are wrapped, not only equal ones.
// RULE_04: corrected pointer written back only for pre/post modify modes.
// RULE_05: register-plus-offset address corrected, pointer left unchanged.
// RULE_06: bit-reversed addressing only on x generator data writes.
// RULE_07: only the modifier is bit-reversed; pointer stays normal order.
// RULE_08: bit reverse disabled when write pointer select is stack code.
// RULE_09: bit reverse needs enable bit and pre/post increment indirect.
// RULE_10: software aligns a 2^N byte buffer to zero low N bits.
// RULE_11: low fifteen bits of bit-reverse control are the modifier.
// RULE_12: bit reverse assumes words; modifier scaled, address lsb forced zero.
// RULE_13: byte writes or other modes give normal addresses.
// RULE_14: bit reverse adds pointer and modifier, ignores normal increment.
// RULE_15: bit reverse takes precedence over modulo for data writes.
// RULE_16: software avoids reading via bit-reverse pointer right after control write.
`include "mbag_defines.vh"

module mbag_top
#(
  parameter AW = 16
)
(
  // clock and reset
  input  wire          clk_in,
  input  wire          reset_n_in,
  // apb slave
  input  wire          psel_in,
  input  wire          penable_in,
  input  wire          pwrite_in,
  input  wire [7:0]    paddr_in,
  input  wire [31:0]   pwdata_in,
  output reg  [31:0]   prdata_out,
  output wire          pready_out,
  output wire          pslverr_out,
  // pipeline request
  input  wire          req_valid_in,
  input  wire [3:0]    req_wreg_in,
  input  wire [2:0]    req_mode_in,
  input  wire          req_write_in,
  input  wire          req_byte_in,
  input  wire          req_xagu_in,
  input  wire [AW-1:0] req_ptr_in,
  input  wire [AW-1:0] req_offset_in,
  // memory address and pointer write-back
  output reg           ea_valid_out,
  output reg  [AW-1:0] ea_out,
  output reg           wb_valid_out,
  output reg  [3:0]    wb_wreg_out,
  output reg  [AW-1:0] wb_value_out,
  output reg           brev_used_out
);

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  reg  [15:0]   bitrev_control_q;
  reg  [15:0]   modulo_control_q;
  reg  [AW-1:0] mod_start_q;
  reg  [AW-1:0] mod_end_q;

  wire          apb_wr;
  wire          addr_hit;

  assign addr_hit    = (paddr_in == `MBAG_OFF_BREV)     ||
                       (paddr_in == `MBAG_OFF_MODCTL)   ||
                       (paddr_in == `MBAG_OFF_MODSTART) ||
                       (paddr_in == `MBAG_OFF_MODEND)   ||
                       (paddr_in == `MBAG_OFF_STATUS);
  assign apb_wr      = psel_in && penable_in && pwrite_in && addr_hit;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_hit;

  always @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      bitrev_control_q <= `MBAG_RST16;
      modulo_control_q <= `MBAG_RST16;
      mod_start_q      <= {AW{1'b0}};
      mod_end_q        <= {AW{1'b0}};
    end
    else if (apb_wr)
    begin
      case (paddr_in)
        `MBAG_OFF_BREV:     bitrev_control_q <= pwdata_in[15:0];
        `MBAG_OFF_MODCTL:   modulo_control_q <= pwdata_in[15:0];
        `MBAG_OFF_MODSTART: mod_start_q      <= pwdata_in[AW-1:0];
        `MBAG_OFF_MODEND:   mod_end_q        <= pwdata_in[AW-1:0];
        default:            mod_end_q        <= mod_end_q;
      endcase
    end
  end

  // ----------------------------------------------------------
  // read data
  // ----------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      prdata_out <= 32'h00000000;
    end
    else if (psel_in && !penable_in && !pwrite_in)
    begin
      case (paddr_in)
        `MBAG_OFF_BREV:     prdata_out <= {16'h0000, bitrev_control_q};
        `MBAG_OFF_MODCTL:   prdata_out <= {16'h0000, modulo_control_q};
        `MBAG_OFF_MODSTART: prdata_out <= {{(32-AW){1'b0}}, mod_start_q};
        `MBAG_OFF_MODEND:   prdata_out <= {{(32-AW){1'b0}}, mod_end_q};
        `MBAG_OFF_STATUS:   prdata_out <= {{(31-AW){1'b0}}, brev_used_out, ea_out};
        default:            prdata_out <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------
  // field decode
  // ----------------------------------------------------------
  wire          bitrev_enable;
  wire [14:0]   brev_modifier;
  wire [3:0]    write_pointer_select;
  wire [3:0]    mod_pointer_select;
  wire          mod_enable;

  assign bitrev_enable        = bitrev_control_q[`MBAG_BREV_EN_BIT];
  assign brev_modifier        = bitrev_control_q[`MBAG_BREV_MOD_MSB:0]; // see RULE_11
  assign write_pointer_select = modulo_control_q[`MBAG_BWP_MSB:`MBAG_BWP_LSB];
  assign mod_pointer_select   = modulo_control_q[`MBAG_XWP_MSB:`MBAG_XWP_LSB];
  assign mod_enable           = modulo_control_q[`MBAG_MOD_EN_BIT];

  // ----------------------------------------------------------
  // bit reversal helper
  // ----------------------------------------------------------
  function [AW-1:0] rev;
    input [AW-1:0] v;
    integer i;
    begin
      rev = {AW{1'b0}};
      for (i = 0; i < AW; i = i + 1)
      begin
        rev[i] = v[AW-1-i];
      end
    end
  endfunction

  // ----------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------
  wire          is_inc_mode;
  wire          is_modify;
  wire          is_pre;
  wire          is_dec;
  wire          brev_act;
  wire          mod_act;
  wire [AW-1:0] step;

  assign is_inc_mode = (req_mode_in == `MBAG_AM_POSTINC) ||
                       (req_mode_in == `MBAG_AM_PREINC);
  assign is_modify   = is_inc_mode ||
                       (req_mode_in == `MBAG_AM_POSTDEC) ||
                       (req_mode_in == `MBAG_AM_PREDEC);
  assign is_pre      = (req_mode_in == `MBAG_AM_PREINC) ||
                       (req_mode_in == `MBAG_AM_PREDEC);
  assign is_dec      = (req_mode_in == `MBAG_AM_POSTDEC) ||
                       (req_mode_in == `MBAG_AM_PREDEC)  ||
                       ((req_mode_in == `MBAG_AM_OFFSET) && req_offset_in[AW-1]);
  assign step        = req_byte_in ? `MBAG_STEP_BYTE : `MBAG_STEP_WORD;

  // see RULE_06 see RULE_08 see RULE_09 see RULE_13
  assign brev_act = bitrev_enable && req_xagu_in && req_write_in && !req_byte_in &&
                    is_inc_mode && (write_pointer_select != `MBAG_STACK_SEL) &&
                    (req_wreg_in == write_pointer_select);
  // any working register may be the modulo pointer
  assign mod_act  = mod_enable && (req_wreg_in == mod_pointer_select); // see RULE_01

  // ----------------------------------------------------------
  // normal and modulo arithmetic
  // ----------------------------------------------------------
  wire [AW-1:0] modified_raw;
  wire [AW-1:0] offset_raw;
  wire [AW-1:0] modified_cor;
  wire [AW-1:0] offset_cor;

  assign modified_raw = is_dec ? (req_ptr_in - step) : (req_ptr_in + step);
  assign offset_raw   = req_ptr_in + req_offset_in;

  mbag_modwrap #(.AW(AW)) u_wrap_mod
  (
    .en_in    (mod_act),
    .dec_in   (is_dec),
    .start_in (mod_start_q),
    .end_in   (mod_end_q),
    .addr_in  (modified_raw),
    .addr_out (modified_cor)
  );

  mbag_modwrap #(.AW(AW)) u_wrap_off
  (
    .en_in    (mod_act),
    .dec_in   (is_dec),
    .start_in (mod_start_q),
    .end_in   (mod_end_q),
    .addr_in  (offset_raw),
    .addr_out (offset_cor)          // see RULE_05
  );

  // ----------------------------------------------------------
  // bit-reversed arithmetic
  // ----------------------------------------------------------
  wire [AW-1:0] brev_mod_bytes;
  wire [AW-1:0] brev_next;

  // modifier scaled to bytes; only it is treated reversed
  assign brev_mod_bytes = {brev_modifier[AW-2:0], 1'b0};              // see RULE_12
  assign brev_next      = rev(rev(req_ptr_in) + rev(brev_mod_bytes)); // see RULE_07 see RULE_14

  // ----------------------------------------------------------
  // effective address and write-back selection
  // ----------------------------------------------------------
  reg  [AW-1:0] ea_d;
  reg  [AW-1:0] wb_d;
  reg           wb_en_d;

  always @*
  begin
    ea_d    = req_ptr_in;
    wb_d    = req_ptr_in;
    wb_en_d = 1'b0;
    if (brev_act)                                // see RULE_15
    begin
      wb_d    = {brev_next[AW-1:1], 1'b0};       // see RULE_12
      wb_en_d = 1'b1;
      ea_d    = is_pre ? {brev_next[AW-1:1], 1'b0} : {req_ptr_in[AW-1:1], 1'b0};
    end
    else if (is_modify)
    begin
      wb_d    = modified_cor;
      wb_en_d = 1'b1;                            // see RULE_04
      ea_d    = is_pre ? modified_cor : req_ptr_in;
    end
    else if (req_mode_in == `MBAG_AM_OFFSET)
    begin
      ea_d    = offset_cor;                      // see RULE_05
      wb_en_d = 1'b0;
    end
  end

  // ----------------------------------------------------------
  // output registers
  // ----------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      ea_valid_out  <= 1'b0;
      ea_out        <= {AW{1'b0}};
      wb_valid_out  <= 1'b0;
      wb_wreg_out   <= 4'h0;
      wb_value_out  <= {AW{1'b0}};
      brev_used_out <= 1'b0;
    end
    else
    begin
      ea_valid_out <= req_valid_in;
      wb_valid_out <= req_valid_in && wb_en_d;   // see RULE_04
      if (req_valid_in)
      begin
        ea_out        <= ea_d;
        wb_wreg_out   <= req_wreg_in;
        wb_value_out  <= wb_d;
        brev_used_out <= brev_act;
      end
    end
  end

endmodule

// ===== verification/mbag_pipe_model.sv
// Purpose: pipeline side model issuing address requests
// Assumes: one request per call, answer one cycle later
// Notes:   pointer and offset fields are scrambled while idle
module mbag_pipe_model
(
  // clock
  input  wire logic        clk_in,
  // request
  output logic             req_valid_out,
  output logic [3:0]       req_wreg_out,
  output logic [2:0]       req_mode_out,
  output logic [2:0]       req_flags_out,
  output logic [15:0]      req_ptr_out,
  output logic [15:0]      req_offset_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {req_valid_out, req_wreg_out, req_mode_out, req_flags_out} = 11'h000;
    req_ptr_out    = 16'h0000;
    req_offset_out = 16'h0000;
  end

  // flags are write, byte, x generator
  task automatic issue(input logic [3:0] w, input logic [2:0] m, input logic [2:0] f,
                       input logic [15:0] p, input logic [15:0] o);
    @(posedge clk_in);
    req_valid_out  <= 1'b1;
    req_wreg_out   <= w;
    req_mode_out   <= m;
    req_flags_out  <= f;
    req_ptr_out    <= p;
    req_offset_out <= o;
    @(posedge clk_in);
    req_valid_out  <= 1'b0;
    req_ptr_out    <= ~p;
    req_offset_out <= ~o;
    @(negedge clk_in);
  endtask
endmodule

// ===== verification/mbag_properties.sv
// Purpose: assertions on the request path of the address generator
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every mbag_top
`include "mbag_defines.vh"
module mbag_checker
#(
  parameter AW = 16
)
(
  // clock, reset, request
  input wire          clk_in,
  input wire          reset_n_in,
  input wire          req_valid_in,
  input wire [3:0]    req_wreg_in,
  input wire [2:0]    req_mode_in,
  input wire          req_write_in,
  input wire          req_byte_in,
  input wire          req_xagu_in,
  input wire [AW-1:0] req_ptr_in,
  // results
  input wire          ea_valid_out,
  input wire [AW-1:0] ea_out,
  input wire          wb_valid_out,
  input wire [3:0]    wb_wreg_out,
  input wire [AW-1:0] wb_value_out,
  input wire          brev_used_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire go  = req_valid_in;
  wire mdf = req_mode_in >= `MBAG_AM_POSTINC && req_mode_in <= `MBAG_AM_PREDEC;

  wb_modify_a:
  assert property (go && mdf |=> ea_valid_out && wb_valid_out && wb_wreg_out == $past(req_wreg_in))
    else $error("no write-back after modify mode");
  wb_offset_a:
  assert property (go && !mdf |=> ea_valid_out && !wb_valid_out) else $error("stray write-back");
  idle_quiet_a:
  assert property (!go |=> !ea_valid_out && !wb_valid_out) else $error("output without request");
  brev_xwrite_a:
  assert property (go && !(req_write_in && req_xagu_in) |=> !brev_used_out)
    else $error("bit reverse off x write");
  brev_byte_a:
  assert property (go && req_byte_in |=> !brev_used_out) else $error("bit reverse on byte");
  brev_mode_a:
  assert property (go && req_mode_in != `MBAG_AM_POSTINC && req_mode_in != `MBAG_AM_PREINC
    |=> !brev_used_out) else $error("bit reverse in wrong mode");
  brev_stack_a:
  assert property (go && req_wreg_in == `MBAG_STACK_SEL |=> !brev_used_out)
    else $error("bit reverse on stack");
  brev_lsb_a:
  assert property (ea_valid_out && brev_used_out |-> !ea_out[0] && !wb_value_out[0])
    else $error("odd bit reversed address");
  brev_pre_a:
  assert property (go && req_mode_in == `MBAG_AM_PREINC |=> !brev_used_out || ea_out == wb_value_out)
    else $error("pre mode address differs");
  brev_post_a:
  assert property (go && req_mode_in == `MBAG_AM_POSTINC
    |=> !brev_used_out || ea_out[AW-1:1] == $past(req_ptr_in[AW-1:1]))
    else $error("post mode address altered");
  cover property (ea_valid_out && brev_used_out);
  cover property (wb_valid_out && !brev_used_out);
  cover property (ea_valid_out && !wb_valid_out);
endmodule

bind mbag_top mbag_checker #(.AW(AW)) i_mbag_checker (.clk_in, .reset_n_in, .req_valid_in,
  .req_wreg_in, .req_mode_in, .req_write_in, .req_byte_in, .req_xagu_in, .req_ptr_in,
  .ea_valid_out, .ea_out, .wb_valid_out, .wb_wreg_out, .wb_value_out, .brev_used_out);

// ===== verification/mbag_testbench.sv
// Purpose: self-checking bench for the address generator
// Assumes: apb slave, pipe model on the request side
// Notes:   circular buffer 16'h1000 to 16'h100F
`include "mbag_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] PO = `MBAG_AM_POSTINC;
  localparam logic [2:0] PR = `MBAG_AM_PREINC;
  localparam logic [2:0] PD = `MBAG_AM_PREDEC;
  localparam logic [2:0] QD = `MBAG_AM_POSTDEC;
  localparam logic [2:0] OF = `MBAG_AM_OFFSET;
  localparam logic [2:0] ID = `MBAG_AM_IND;
  logic        clk_in = 1'b0, reset_n_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, err, rv, ev, wv, bu;
  logic [3:0]  rw, ww;
  logic [2:0]  rm, rf;
  logic [15:0] rp, ro, ea, wb;
  int          miscompares = 0, n_checks = 0;

  always #20 clk_in = ~clk_in;

  mbag_top #(.AW(16)) i_mbag_top (.clk_in, .reset_n_in, .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .req_valid_in(rv), .req_wreg_in(rw),
    .req_mode_in(rm), .req_write_in(rf[2]), .req_byte_in(rf[1]), .req_xagu_in(rf[0]),
    .req_ptr_in(rp), .req_offset_in(ro), .ea_valid_out(ev), .ea_out(ea), .wb_valid_out(wv),
    .wb_wreg_out(ww), .wb_value_out(wb), .brev_used_out(bu));
  mbag_pipe_model u_pipe (.clk_in, .req_valid_out(rv), .req_wreg_out(rw), .req_mode_out(rm),
    .req_flags_out(rf), .req_ptr_out(rp), .req_offset_out(ro));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1)
      @(posedge clk_in);
    rdat    = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // flags f are write, byte, x generator
  task automatic rq(input logic [3:0] w, input logic [2:0] m, input logic [2:0] f,
                    input logic [15:0] p, input logic [15:0] o, input logic [15:0] e,
                    input logic v, input logic [15:0] b, input logic u);
    u_pipe.issue(w, m, f, p, o);
    chk({15'h0, ev, ea}, {16'h1, e});
    chk({30'h0, wv, bu}, {30'h0, v, u});
    if (v)
      chk({12'h0, ww, wb}, {12'h0, w, b});
  endtask

  initial
  begin
    #100000;
    miscompares++;
    end_sim();
  end

  initial
  begin
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(`MBAG_OFF_BREV, 32'h0);
    rd(`MBAG_OFF_MODCTL, 32'h0);
    rd(8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `MBAG_OFF_MODSTART, 32'h1000);
    apb(1'b1, `MBAG_OFF_MODEND, 32'h100F);
    apb(1'b1, `MBAG_OFF_MODCTL, 32'h80F3);
    rq(4'h3, PO, 3'b101, 16'h100E, 16'h0, 16'h100E, 1, 16'h1000, 0);
    rq(4'h3, OF, 3'b101, 16'h100C, 16'h6, 16'h1002, 0, 16'h0, 0);
    rq(4'h3, OF, 3'b101, 16'h1002, 16'hFFFC, 16'h100E, 0, 16'h0, 0);
    rq(4'h3, PD, 3'b101, 16'h1000, 16'h0, 16'h100E, 1, 16'h100E, 0);
    rq(4'h3, PR, 3'b111, 16'h100F, 16'h0, 16'h1000, 1, 16'h1000, 0);
    apb(1'b1, `MBAG_OFF_BREV, 32'h8004);
    rd(`MBAG_OFF_BREV, 32'h8004);
    apb(1'b1, `MBAG_OFF_MODCTL, 32'h8022); // pointer use waits
    rq(4'h2, PO, 3'b101, 16'h1000, 16'h0, 16'h1000, 1, 16'h1008, 1);
    rq(4'h2, PO, 3'b101, 16'h1008, 16'h0, 16'h1008, 1, 16'h1004, 1);
    rq(4'h2, PR, 3'b101, 16'h100C, 16'h0, 16'h1002, 1, 16'h1002, 1);
    rq(4'h2, PO, 3'b101, 16'h1001, 16'h0, 16'h1000, 1, 16'h1008, 1);
    apb(1'b1, `MBAG_OFF_STATUS, 32'h0000FFFF);
    chk({31'h0, err}, 32'h0);
    rd(`MBAG_OFF_STATUS, 32'h00011000);
    rq(4'h2, PO, 3'b111, 16'h1000, 16'h0, 16'h1000, 1, 16'h1001, 0);
    rq(4'h2, PO, 3'b001, 16'h1000, 16'h0, 16'h1000, 1, 16'h1002, 0);
    rq(4'h2, PO, 3'b100, 16'h1000, 16'h0, 16'h1000, 1, 16'h1002, 0);
    rq(4'h2, QD, 3'b101, 16'h1004, 16'h0, 16'h1004, 1, 16'h1002, 0);
    rq(4'h2, OF, 3'b101, 16'h1000, 16'h2, 16'h1002, 0, 16'h0, 0);
    rq(4'h2, ID, 3'b101, 16'h1004, 16'h0, 16'h1004, 0, 16'h0, 0);
    apb(1'b1, `MBAG_OFF_MODCTL, 32'h80F2);
    rq(4'h2, PO, 3'b101, 16'h1000, 16'h0, 16'h1000, 1, 16'h1002, 0);
    rq(4'hF, PO, 3'b101, 16'h1000, 16'h0, 16'h1000, 1, 16'h1002, 0);
    apb(1'b1, `MBAG_OFF_BREV, 32'h0004);
    apb(1'b1, `MBAG_OFF_MODCTL, 32'h8022);
    rq(4'h2, PO, 3'b101, 16'h1000, 16'h0, 16'h1000, 1, 16'h1002, 0);
    end_sim();
  end
endmodule
